// ==== inc/lfc_pkg.sv ====
// constants and types for the low-frequency oscillator control block
package lfc_pkg;
    localparam int SYS_HZ = 50_000_000;
    localparam int LF_NOM_HZ = 80_000;
    localparam int LF_HALF_CYC = SYS_HZ / (2 * LF_NOM_HZ);
    localparam int LF_TRIM_STEP = 8;
    localparam int LF_TRIM_MID = 8;
    localparam int LF_SETTLE_US = 20;
    localparam int LF_SETTLE_CYC = LF_SETTLE_US * (SYS_HZ / 1_000_000);
    localparam int ADDR_W = 12;
    localparam logic [7:0] LF_CTRL_IDX = 8'h86;
    localparam logic [7:0] HF_CAL_IDX = 8'hb3;
    localparam logic [7:0] IRQ_STAT_IDX = 8'hc0;
    localparam logic [7:0] IRQ_MASK_IDX = 8'hc1;
    localparam logic [ADDR_W-1:0] LF_CTRL_ADDR = {2'b00, LF_CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] HF_CAL_ADDR = {2'b00, HF_CAL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {2'b00, IRQ_STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {2'b00, IRQ_MASK_IDX, 2'b00};
    localparam int EN_BIT = 7;
    localparam int RDY_BIT = 6;
    localparam int TRIM_LSB = 2;
    localparam int DIV_LSB = 0;
    localparam int CAL_LSB = 0;
    localparam int EV_RDY = 0;
    localparam int EV_FALL = 1;
    localparam int EV_RISE = 2;
    localparam logic [3:0] LF_TRIM_RST = 4'h0;
    localparam logic [1:0] LF_DIV_RST = 2'h0;
    localparam logic [4:0] HF_CAL_DEFAULT = 5'h10;
    localparam logic [1:0] DIV_BY8 = 2'b00;
    localparam logic [1:0] DIV_BY4 = 2'b01;
    localparam logic [1:0] DIV_BY2 = 2'b10;
    localparam logic [1:0] DIV_BY1 = 2'b11;

    typedef enum logic [2:0] {
        LS_OFF = 3'b001,
        LS_SETTLE = 3'b010,
        LS_RUN = 3'b100
    } lfc_state_type;

    typedef struct packed {
        lfc_state_type state;
        logic en;
        logic [3:0] trim;
        logic [1:0] div;
        logic [4:0] cal;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [8:0] half_cnt;
        logic [9:0] settle_cnt;
        logic raw;
        logic [2:0] dcnt;
        logic out;
        logic t2;
        logic t3;
        logic pready;
        logic perr;
        logic [31:0] prdata;
        logic irq;
    } lfc_regs_type;

    // half period in system cycles; trim 0 fastest, nominal 80 kHz at mid trim
    function automatic logic [8:0] lfc_half(input logic [3:0] trim);
        lfc_half = 9'(LF_HALF_CYC - LF_TRIM_MID * LF_TRIM_STEP
                      + int'(trim) * LF_TRIM_STEP);
    endfunction
endpackage

// ==== rtl/lfc_osc_ctrl.sv ====
// low-frequency oscillator control, trim, divider and capture edge outputs
//
// Operation
// - oscillator runs at nominal 80 kHz before division or trim offset
// - divider select bits 1:0: 00 by 8, 01 by 4, 10 by 2, 11 by 1
// - four-bit trim in bits 5:2; 0000 fastest, 1111 slowest
// - second timer capture mode: each falling output edge raises a capture
// - third timer capture mode: each rising output edge raises a capture
// - high-frequency calibration resets to the factory value for 12 MHz
`timescale 1ns/1ns
`default_nettype none
module lfc_osc_ctrl
    import lfc_pkg::*;
#(
    parameter logic [4:0] HF_CAL_RESET = HF_CAL_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic t2_capture_mode,
    input wire logic t3_capture_mode,
    output logic lf_osc_out,
    output logic t2_capture,
    output logic t3_capture,
    output logic [4:0] hf_period_trim,
    output logic irq
);
    lfc_regs_type r_reg;
    lfc_regs_type r_next;
    logic access;
    logic setup;
    logic [2:0] ev;

    always_comb begin
        r_next = r_reg;
        r_next.t2 = 1'b0;
        r_next.t3 = 1'b0;
        r_next.pready = 1'b0;
        r_next.perr = 1'b0;
        ev = 3'b000;
        setup = psel && !penable;
        access = psel && penable && r_reg.pready;
        // answer one cycle after setup; read data is frozen at that point
        if (setup) begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'h0000_0000;
            case (paddr)
                LF_CTRL_ADDR: begin
                    r_next.prdata[EN_BIT] = r_reg.en;
                    r_next.prdata[RDY_BIT] = (r_reg.state == LS_RUN);
                    r_next.prdata[TRIM_LSB +: 4] = r_reg.trim;
                    r_next.prdata[DIV_LSB +: 2] = r_reg.div;
                end
                HF_CAL_ADDR: r_next.prdata[CAL_LSB +: 5] = r_reg.cal;
                IRQ_STAT_ADDR: r_next.prdata[2:0] = r_reg.stat;
                IRQ_MASK_ADDR: r_next.prdata[2:0] = r_reg.mask;
                default: r_next.perr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                LF_CTRL_ADDR: begin
                    r_next.en = pwdata[EN_BIT];
                    r_next.trim = pwdata[TRIM_LSB +: 4];
                    r_next.div = pwdata[DIV_LSB +: 2];
                end
                HF_CAL_ADDR: r_next.cal = pwdata[CAL_LSB +: 5];
                IRQ_MASK_ADDR: r_next.mask = pwdata[2:0];
                default: ;
            endcase
        end
        // enable, settle, run; ready only after the settle count
        case (r_reg.state)
            LS_OFF: begin
                if (r_reg.en) begin
                    r_next.state = LS_SETTLE;
                    r_next.settle_cnt = 10'd0;
                end
            end
            LS_SETTLE: begin
                if (!r_reg.en) begin
                    r_next.state = LS_OFF;
                end else if (r_reg.settle_cnt == 10'(LF_SETTLE_CYC - 1)) begin
                    r_next.state = LS_RUN;
                    ev[EV_RDY] = 1'b1;
                end else begin
                    r_next.settle_cnt = r_reg.settle_cnt + 10'd1;
                end
            end
            LS_RUN: begin
                if (!r_reg.en) begin
                    r_next.state = LS_OFF;
                end
            end
            default: r_next.state = LS_OFF;
        endcase
        // stopped oscillator parks low so no stray capture edges appear
        if (r_next.state == LS_OFF) begin
            r_next.half_cnt = 9'd0;
            r_next.raw = 1'b0;
            r_next.dcnt = 3'd0;
        end else if (r_reg.half_cnt >= lfc_half(r_reg.trim) - 9'd1) begin
            // compare with >= so a trim cut mid-period ends at once
            r_next.half_cnt = 9'd0;
            r_next.raw = ~r_reg.raw;
            if (!r_reg.raw) begin
                r_next.dcnt = r_reg.dcnt + 3'd1;
            end
        end else begin
            r_next.half_cnt = r_reg.half_cnt + 9'd1;
        end
        case (r_reg.div)
            DIV_BY1: r_next.out = r_next.raw;
            DIV_BY2: r_next.out = r_next.dcnt[0];
            DIV_BY4: r_next.out = r_next.dcnt[1];
            DIV_BY8: r_next.out = r_next.dcnt[2];
            default: r_next.out = r_next.raw;
        endcase
        ev[EV_FALL] = r_reg.out && !r_next.out;
        ev[EV_RISE] = !r_reg.out && r_next.out;
        r_next.t2 = ev[EV_FALL] && t2_capture_mode;
        r_next.t3 = ev[EV_RISE] && t3_capture_mode;
        // set wins over the read clear; only bits already shown in the read are cleared,
        // so an event landing between setup and access is not lost
        if (access && !pwrite && paddr == IRQ_STAT_ADDR) begin
            r_next.stat = (r_reg.stat & ~r_reg.prdata[2:0]) | ev;
        end else begin
            r_next.stat = r_reg.stat | ev;
        end
        r_next.irq = |(r_next.stat & r_next.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.state <= LS_OFF;
            r_reg.trim <= LF_TRIM_RST;
            r_reg.div <= LF_DIV_RST;
            r_reg.cal <= HF_CAL_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.perr;
    assign lf_osc_out = r_reg.out;
    assign t2_capture = r_reg.t2;
    assign t3_capture = r_reg.t3;
    assign hf_period_trim = r_reg.cal;
    assign irq = r_reg.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    nominal_rate_a:
        assert property ($changed(r_reg.raw) && $past(r_reg.state) != LS_OFF
                         && r_reg.state != LS_OFF
                         && $past(r_reg.trim) == 4'(LF_TRIM_MID)
                         && $stable(r_reg.trim)
                         |-> $past(r_reg.half_cnt) == 9'(LF_HALF_CYC - 1))
        else $error("raw half period not nominal at mid trim");

    div_eight_a:
        assert property ($changed(r_reg.out) && r_reg.div == DIV_BY8
                         && $stable(r_reg.div) && r_reg.state != LS_OFF
                         && $past(r_reg.div, 2) == DIV_BY8
                         |-> r_reg.dcnt[1:0] == 2'b00)
        else $error("divide by eight edge misplaced");

    div_one_a:
        assert property (r_reg.div == DIV_BY1 && $stable(r_reg.div)
                         |-> r_reg.out == r_reg.raw)
        else $error("divide by one output differs from oscillator");

    trim_order_a:
        assert property (r_reg.trim != 4'hf
                         |-> lfc_half(r_reg.trim + 4'h1) > lfc_half(r_reg.trim))
        else $error("higher trim not slower");

    fall_capture_a:
        assert property ($fell(r_reg.out) |-> r_reg.t2 == $past(t2_capture_mode)
                         ##1 !r_reg.t2)
        else $error("falling edge capture pulse wrong");

    rise_capture_a:
        assert property ($rose(r_reg.out) |-> r_reg.t3 == $past(t3_capture_mode)
                         ##1 !r_reg.t3)
        else $error("rising edge capture pulse wrong");

    cal_reset_a:
        assert property ($past(rst) |-> hf_period_trim == HF_CAL_RESET)
        else $error("calibration not at factory value after reset");

    cal_write_a:
        assert property (access && pwrite && paddr == HF_CAL_ADDR
                         |=> hf_period_trim == $past(pwdata[4:0]))
        else $error("calibration write not taken");

    ready_wait_a:
        assert property ($rose(r_reg.en) |=> r_reg.state != LS_RUN [*8])
        else $error("ready before settle time");

    ready_en_a:
        assert property (r_reg.state == LS_RUN |-> $past(r_reg.en))
        else $error("ready without enable");

    setup_answer_a:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");

    pready_single_a:
        assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");

    error_answer_a:
        assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without answer or with data");

    ctrl_read_a:
        assert property (setup && paddr == LF_CTRL_ADDR
                         |=> prdata == {24'h00_0000, $past(r_reg.en),
                                        $past(r_reg.state) == LS_RUN,
                                        $past(r_reg.trim), $past(r_reg.div)})
        else $error("control read data wrong");

    cal_read_a:
        assert property (setup && paddr == HF_CAL_ADDR
                         |=> prdata == {27'h000_0000, $past(r_reg.cal)})
        else $error("calibration read data wrong");

    ctrl_write_a:
        assert property (access && pwrite && paddr == LF_CTRL_ADDR
                         |=> r_reg.en == $past(pwdata[EN_BIT])
                         && r_reg.trim == $past(pwdata[TRIM_LSB +: 4])
                         && r_reg.div == $past(pwdata[DIV_LSB +: 2]))
        else $error("control write not taken");

    mask_write_a:
        assert property (access && pwrite && paddr == IRQ_MASK_ADDR
                         |=> r_reg.mask == $past(pwdata[2:0]))
        else $error("mask write not taken");

    unmapped_write_a:
        assert property (access && pwrite && pslverr
                         |=> $stable(r_reg.en) && $stable(r_reg.trim)
                         && $stable(r_reg.div) && $stable(r_reg.cal)
                         && $stable(r_reg.mask))
        else $error("write to unmapped address changed a register");

    cal_hold_a:
        assert property (!(access && pwrite && paddr == HF_CAL_ADDR)
                         |=> $stable(hf_period_trim))
        else $error("calibration changed without write");

    // status is sticky: an event always lands, a bit only goes on a read
    stat_set_a:
        assert property (ev != 3'b000 |=> (r_reg.stat & $past(ev)) == $past(ev))
        else $error("event lost from status");

    stat_hold_a:
        assert property (!(access && !pwrite && paddr == IRQ_STAT_ADDR)
                         |=> (r_reg.stat & $past(r_reg.stat)) == $past(r_reg.stat))
        else $error("status bit dropped without read");

    irq_level_a:
        assert property (irq == |(r_reg.stat & r_reg.mask))
        else $error("interrupt level differs from status and mask");

    settle_count_a:
        assert property ($rose(r_reg.state == LS_RUN)
                         |-> $past(r_reg.settle_cnt) == 10'(LF_SETTLE_CYC - 1))
        else $error("ready before full settle count");

    ready_event_a:
        assert property ($rose(r_reg.state == LS_RUN) |-> r_reg.stat[EV_RDY])
        else $error("ready event not flagged");

    off_quiet_a:
        assert property (r_reg.state == LS_OFF |-> !lf_osc_out && r_reg.dcnt == 3'd0)
        else $error("output active while oscillator off");

    // a trim cut mid-period must never leave the counter beyond the slowest half
    half_bound_a:
        assert property (r_reg.state != LS_OFF |-> r_reg.half_cnt < lfc_half(4'hf))
        else $error("half period counter out of range");

    t2_mode_a:
        assert property (!$past(t2_capture_mode) |-> !t2_capture)
        else $error("falling capture without capture mode");

    t3_mode_a:
        assert property (!$past(t3_capture_mode) |-> !t3_capture)
        else $error("rising capture without capture mode");
endmodule
`default_nettype wire

// ==== test/lfc_timer_model.sv ====
// timer partner: counts the reference clock, copies count to reload on capture
`timescale 1ns/1ns
`default_nettype none
module lfc_timer_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic capture,
    output logic [15:0] count_value,
    output logic [15:0] reload_value
);
    // counts sys_clk only, so one capture difference is a period in system cycles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_value <= 16'h0000;
            reload_value <= 16'h0000;
        end else begin
            count_value <= count_value + 16'h0001;
            if (capture) begin
                reload_value <= count_value;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/lf_oscillator_control_and_trim_bench.sv ====
// self-checking bench for the low-frequency oscillator control block
`timescale 1ns/1ns
`default_nettype none
module lf_oscillator_control_and_trim_bench;
    import lfc_pkg::*;
    logic sys_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, lf_osc_out, t2_capture, t3_capture, irq;
    logic [4:0] hf_period_trim;
    logic [15:0] r2, r3;
    logic [31:0] rd;
    logic er;
    logic t2_mode = 1;
    logic t3_mode = 1;
    int error_cnt = 0;
    int n_tests = 0;
    always #10 sys_clk = ~sys_clk;
    lfc_osc_ctrl u_lfc_osc_ctrl (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .t2_capture_mode(t2_mode), .t3_capture_mode(t3_mode), .lf_osc_out(lf_osc_out),
        .t2_capture(t2_capture), .t3_capture(t3_capture),
        .hf_period_trim(hf_period_trim), .irq(irq));
    lfc_timer_model u_lfc_timer_model (.sys_clk(sys_clk), .rst(rst),
        .capture(t2_capture), .count_value(), .reload_value(r2));
    lfc_timer_model u_lfc_timer_model_3 (.sys_clk(sys_clk), .rst(rst),
        .capture(t3_capture), .count_value(), .reload_value(r3));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // request stands until pready is seen high at a rising edge; data taken there
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
            chk("pready", 32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic cap(input logic sel, output logic [15:0] v);
        int n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while ((sel ? t3_capture : t2_capture) !== 1'b1 && n < 7000);
        if (n >= 7000)
            chk("capture_wait", 32'(n), 32'h0000_0000);
        @(posedge sys_clk);
        #1 v = sel ? r3 : r2;
    endtask
    // first capture after a setting change is thrown away
    task automatic per(input logic sel, input int exp);
        logic [15:0] a, b, d;
        cap(sel, a);
        cap(sel, a);
        cap(sel, b);
        d = b - a;
        chk("period", 32'(d), 32'(exp));
    endtask
    task automatic t_reset;
        apb(0, LF_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl_rst", rd, 32'h0000_0000);
        apb(0, HF_CAL_ADDR, 32'h0000_0000);
        chk("cal_rst", rd, 32'(HF_CAL_DEFAULT));
        chk("cal_pin", 32'(hf_period_trim), 32'(HF_CAL_DEFAULT));
        apb(0, 12'h004, 32'h0000_0000);
        chk("unmapped", {31'h0000_0000, er}, 32'h0000_0001);
        apb(1, HF_CAL_ADDR, 32'hffff_ffff);
        apb(0, HF_CAL_ADDR, 32'h0000_0000);
        chk("cal_rw", rd, 32'h0000_001f);
        chk("cal_pin", 32'(hf_period_trim), 32'h0000_001f);
        $display("test registers done");
    endtask
    task automatic t_enable;
        int n = 0;
        apb(1, LF_CTRL_ADDR, 32'h0000_0040);
        apb(0, LF_CTRL_ADDR, 32'h0000_0000);
        chk("ready_ro", rd, 32'h0000_0000);
        apb(1, IRQ_MASK_ADDR, 32'h0000_0001);
        apb(1, LF_CTRL_ADDR, 32'h0000_0083);
        apb(0, LF_CTRL_ADDR, 32'h0000_0000);
        chk("not_ready", rd, 32'h0000_0083);
        while (irq !== 1'b1 && n < 1100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("settle", 32'(n >= 985 && n <= 1005), 32'h0000_0001);
        apb(0, LF_CTRL_ADDR, 32'h0000_0000);
        chk("ready", rd, 32'h0000_00c3);
        apb(0, IRQ_STAT_ADDR, 32'h0000_0000);
        chk("stat_set", 32'(rd[0]), 32'h0000_0001);
        apb(0, IRQ_STAT_ADDR, 32'h0000_0000);
        chk("stat_clr", 32'(rd[0]), 32'h0000_0000);
        apb(1, IRQ_MASK_ADDR, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        #1 chk("irq_off", 32'(irq), 32'h0000_0000);
        $display("test enable done");
    endtask
    task automatic t_period;
        for (int c = 0; c < 4; c++) begin
            apb(1, LF_CTRL_ADDR, 32'h0000_0080 | 32'(c));
            per(0, 2 * (LF_HALF_CYC - LF_TRIM_MID * LF_TRIM_STEP) * (8 >> c));
        end
        apb(1, LF_CTRL_ADDR, 32'h0000_00a3);
        per(1, 2 * LF_HALF_CYC);
        apb(1, LF_CTRL_ADDR, 32'h0000_00bf);
        per(1, 2 * (LF_HALF_CYC + (15 - LF_TRIM_MID) * LF_TRIM_STEP));
        $display("test period done");
    endtask
    // one timer out of capture mode must see no pulse while the other still does
    task automatic t_mode;
        int a;
        int b;
        for (int s = 0; s < 2; s++) begin
            a = 0;
            b = 0;
            @(posedge sys_clk);
            t2_mode <= (s != 0);
            t3_mode <= (s == 0);
            repeat (1600) begin
                @(posedge sys_clk);
                #1 a += (s == 0) ? t2_capture : t3_capture;
                b += (s == 0) ? t3_capture : t2_capture;
            end
            chk("mode_off", 32'(a), 32'h0000_0000);
            chk("mode_on", 32'(b >= 2), 32'h0000_0001);
        end
        @(posedge sys_clk);
        t2_mode <= 1;
        t3_mode <= 1;
        $display("test capture mode done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        t_reset;
        t_enable;
        t_period;
        t_mode;
        conclude;
    end
    initial begin
        #(80_000 * 20);
        error_cnt++;
        conclude;
    end
endmodule
`default_nettype wire
